/* verification/uhim_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import uhim_pkg::*;

   // ============================================================
   // expected-result note: irq flag plus value
   // ============================================================
   typedef struct packed {
      logic        is_irq;
      logic [31:0] v;
   } uhim_exp_t;

   logic              clk_in;
   logic              rst_n_in;
   logic              soft_reset_in;
   logic              hsel_in;
   logic [31:0]       haddr_in;
   logic [1:0]        htrans_in;
   logic              hwrite_in;
   logic [2:0]        hsize_in;
   logic [31:0]       hwdata_in;
   uhim_events_t      events_in;
   logic [31:0]       hrdata_out;
   logic              hreadyout_out;
   logic              hresp_out;
   logic              irq_out;
   logic              probe;
   logic              rd_pend;
   logic [31:0]       seen;
   logic [31:0]       m;
   logic [31:0]       b;
   logic [31:0]       w;
   logic [2:0]        sz;
   uhim_exp_t         e;
   uhim_exp_t         exp_q[$];
   int                n_mismatch;
   int                checks_done;
   int                cycles;
   integer            seed;
   int                pos[7] = '{0, 1, 2, 3, 5, 6, 30};

   // ============================================================
   // clock and design
   // ============================================================
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   // one slave on the bus, so its ready is the bus ready
   uhim_top i_dut (
      .clk_in        (clk_in),
      .rst_n_in      (rst_n_in),
      .soft_reset_in (soft_reset_in),
      .hsel_in       (hsel_in),
      .haddr_in      (haddr_in),
      .htrans_in     (htrans_in),
      .hwrite_in     (hwrite_in),
      .hsize_in      (hsize_in),
      .hwdata_in     (hwdata_in),
      .hready_in     (hreadyout_out),
      .events_in     (events_in),
      .hrdata_out    (hrdata_out),
      .hreadyout_out (hreadyout_out),
      .hresp_out     (hresp_out),
      .irq_out       (irq_out)
   );

   // ============================================================
   // verdict and bus tasks
   // ============================================================
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // single transfer of size sz; waits on ready, never on a fixed count
   task automatic bus(input logic [31:0] a, input logic wr,
                      input logic [31:0] d);
      @(posedge clk_in);
      hsel_in   <= 1'b1;
      haddr_in  <= a;
      hwrite_in <= wr;
      htrans_in <= HTRANS_NONSEQ;
      hsize_in  <= sz;
      do @(posedge clk_in); while (hreadyout_out !== 1'b1);
      hsel_in   <= 1'b0;
      htrans_in <= 2'h0;
      hwdata_in <= d;
      do @(posedge clk_in); while (hreadyout_out !== 1'b1);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] x);
      exp_q.push_back({1'b0, x});
      bus(a, 1'b0, 32'h0000_0000);
   endtask

   // probe is seen by the monitor one edge later
   task automatic chk_irq(input logic x);
      exp_q.push_back({1'b1, 31'h0000_0000, x});
      @(posedge clk_in);
      probe <= 1'b1;
      @(posedge clk_in);
      probe <= 1'b0;
   endtask

   task automatic pulse(input int i);
      @(posedge clk_in);
      events_in <= uhim_events_t'(7'h01 << i);
      @(posedge clk_in);
      events_in <= uhim_events_t'(7'h00);
   endtask

   // ============================================================
   // monitor: takes the oldest note when a result appears
   // ============================================================
   always @(posedge clk_in) begin
      if ((rd_pend && hreadyout_out) || probe) begin
         seen = probe ? {31'h0000_0000, irq_out} : hrdata_out;
         checks_done++;
         if (hresp_out !== 1'b0) begin
            n_mismatch++;
            $display("wrong value hresp_out expected 0 seen %b", hresp_out);
         end
         if (exp_q.size() == 0) begin
            n_mismatch++;
            $display("wrong value queue expected note seen %h", seen);
         end else begin
            e = exp_q.pop_front();
            if ({probe, seen} !== {e.is_irq, e.v}) begin
               n_mismatch++;
               $display("wrong value %s expected %h seen %h",
                        probe ? "irq_out" : "hrdata_out", e.v, seen);
            end
         end
         rd_pend = 1'b0;
      end
      if (hsel_in && htrans_in == HTRANS_NONSEQ && hreadyout_out
          && !hwrite_in) begin
         rd_pend = 1'b1;
      end
   end

   // hang guard, well above the 141 transfers used
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         n_mismatch++;
         $display("wrong value cycle limit expected 6000 seen %0d", cycles);
         end_sim();
      end
   end

   // ============================================================
   // main sequence
   // ============================================================
   initial begin
      seed = 32'hE62C;
      {soft_reset_in, hsel_in, hwrite_in, probe, rd_pend} = 5'h00;
      {haddr_in, hwdata_in} = 64'h0;
      htrans_in = 2'h0;
      hsize_in = HSIZE_WORD;
      sz = HSIZE_WORD;
      events_in = uhim_events_t'(7'h00);
      {n_mismatch, checks_done, cycles} = 0;
      rst_n_in = 1'b0;
      repeat (20) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(OFF_MASK_CLR, MASK_RESET);
      rd(OFF_MASK_SET, MASK_RESET);
      $display("test reset values done");
      wr(OFF_MASK_SET, 32'hFFFF_FFFF);
      rd(OFF_MASK_SET, MASK_IMPL);
      wr(OFF_MASK_CLR, 32'h0000_0000);
      rd(OFF_MASK_CLR, MASK_IMPL);
      m = MASK_IMPL;
      // one clear-view bit at a time, others must survive
      for (int i = 0; i < 7; i++) begin
         wr(OFF_MASK_CLR, 32'h1 << pos[i]);
         m[pos[i]] = 1'b0;
         rd(OFF_MASK_CLR, m);
      end
      wr(OFF_MASK_CLR, 32'h8000_0000);
      rd(OFF_MASK_SET, 32'h0000_0000);
      $display("test mask views done");
      // each event: masked, enabled, disabled, gated, flag cleared
      for (int i = 0; i < 7; i++) begin
         b = 32'h1 << pos[i];
         wr(OFF_MASK_SET, MASK_IMPL & ~b);
         pulse(i);
         chk_irq(1'b0);
         rd(OFF_EVENT_FLAG, b);
         wr(OFF_MASK_SET, b);
         chk_irq(1'b1);
         wr(OFF_MASK_CLR, b);
         chk_irq(1'b0);
         wr(OFF_MASK_SET, b);
         wr(OFF_MASK_CLR, 32'h0000_0000);
         chk_irq(1'b1);
         wr(OFF_MASK_CLR, 32'h8000_0000);
         chk_irq(1'b0);
         wr(OFF_MASK_SET, 32'h8000_0000);
         chk_irq(1'b1);
         wr(OFF_EVENT_FLAG, b);
         chk_irq(1'b0);
         rd(OFF_EVENT_FLAG, 32'h0000_0000);
         wr(OFF_MASK_CLR, 32'hFFFF_FFFF);
      end
      $display("test interrupt gating done");
      // an event in the clearing cycle must keep its flag
      fork
         wr(OFF_EVENT_FLAG, 32'h0000_0004);
         begin
            repeat (2) @(posedge clk_in);
            events_in <= uhim_events_t'(7'h04);
            @(posedge clk_in);
            events_in <= uhim_events_t'(7'h00);
         end
      join
      rd(OFF_EVENT_FLAG, 32'h0000_0004);
      wr(OFF_EVENT_FLAG, 32'h0000_0004);
      rd(OFF_EVENT_FLAG, 32'h0000_0000);
      $display("test flag set wins done");
      m = 32'h0000_0000;
      // random words through both views
      for (int k = 0; k < 8; k++) begin
         w = $random(seed);
         wr(OFF_MASK_SET, w);
         m = (m | w) & MASK_IMPL;
         rd(OFF_MASK_SET, m);
         w = $random(seed);
         wr(OFF_MASK_CLR, w);
         m = m & ~w;
         rd(OFF_MASK_CLR, m);
      end
      $display("test random masks done");
      wr(OFF_MASK_SET, MASK_IMPL);
      @(posedge clk_in);
      soft_reset_in <= 1'b1;
      @(posedge clk_in);
      soft_reset_in <= 1'b0;
      rd(OFF_MASK_CLR, MASK_RESET);
      // sub-word and unmapped writes must not reach the mask
      sz = 3'h0;
      wr(OFF_MASK_SET, 32'h0000_0001);
      sz = HSIZE_WORD;
      wr(32'h0000_0018, 32'hFFFF_FFFF);
      rd(OFF_MASK_SET, MASK_RESET);
      rd(32'h0000_0018, 32'h0000_0000);
      $display("test soft reset done");
      repeat (4) @(posedge clk_in);
      if (exp_q.size() != 0) begin
         n_mismatch++;
         $display("wrong value notes left expected 0 seen %0d",
                  exp_q.size());
      end
      end_sim();
   end

endmodule
`default_nettype wire

/* verilog/uhim_ahb_slave.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// ahb-lite slave: zero-wait writes, one wait state on reads
// ============================================================
module uhim_ahb_slave
   import uhim_pkg::*;
(
   input  wire logic        clk_in,        // controller clock
   input  wire logic        rst_n_in,      // async reset, low
   input  wire logic        hsel_in,       // slave select
   input  wire logic [31:0] haddr_in,      // byte address
   input  wire logic [1:0]  htrans_in,     // transfer type
   input  wire logic        hwrite_in,     // write when high
   input  wire logic [2:0]  hsize_in,      // transfer size
   input  wire logic [31:0] hwdata_in,     // write data
   input  wire logic        hready_in,     // bus ready
   input  wire logic [31:0] rd_data_in,    // register read value
   output logic      [31:0] hrdata_out,    // read data
   output logic             hreadyout_out, // slave ready
   output logic             hresp_out,     // always okay
   output uhim_wr_t         wr_out,        // register write
   output logic      [31:0] rd_addr_out    // address being read
);

   typedef enum {S_IDLE, S_WR, S_RD_LOAD, S_RD_OUT} uhim_bus_state_t;

   uhim_bus_state_t state_reg, state_next;
   logic [31:0]     addr_reg, addr_next;
   logic [31:0]     hrdata_reg, hrdata_next;
   logic            size_ok_reg, size_ok_next;
   logic            addr_take;

   // address phase is sampled only while the bus is ready
   assign addr_take = hsel_in && (htrans_in == HTRANS_NONSEQ) && hready_in;

   // next state; the read wait state lets a write still in its
   // data phase land before the read value is captured
   always_comb begin
      state_next   = S_IDLE;
      addr_next    = addr_reg;
      hrdata_next  = hrdata_reg;
      size_ok_next = size_ok_reg;
      case (state_reg)
         S_RD_LOAD: begin
            hrdata_next = rd_data_in;
            state_next  = S_RD_OUT;
         end
         default: begin
            if (addr_take) begin
               addr_next    = haddr_in;
               size_ok_next = (hsize_in == HSIZE_WORD);
               state_next   = hwrite_in ? S_WR : S_RD_LOAD;
            end
         end
      endcase
   end

   // state registers
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg   <= S_IDLE;
         addr_reg    <= ADDR_RESET;
         hrdata_reg  <= RDATA_RESET;
         size_ok_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         addr_reg    <= addr_next;
         hrdata_reg  <= hrdata_next;
         size_ok_reg <= size_ok_next;
      end
   end

   // outputs; sub-word writes are dropped, still answered okay
   assign hrdata_out    = hrdata_reg;
   assign hreadyout_out = (state_reg != S_RD_LOAD);
   assign hresp_out     = 1'b0;
   assign wr_out.strobe = (state_reg == S_WR) && size_ok_reg;
   assign wr_out.addr   = addr_reg;
   assign wr_out.data   = hwdata_in;
   assign rd_addr_out   = addr_reg;

   // read answer always comes after exactly one wait state
   a_read_wait_one: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (addr_take && !hwrite_in) |=> !hreadyout_out ##1 hreadyout_out)
      else $error("read did not answer after one wait state");

endmodule
`default_nettype wire

/* verilog/uhim_pkg.sv */
`default_nettype none
// ============================================================
// shared constants and carriers for the interrupt mask pair
// ============================================================
package uhim_pkg;

   // register byte addresses
   localparam logic [31:0] OFF_EVENT_FLAG = 32'h0000_000C;
   localparam logic [31:0] OFF_MASK_SET   = 32'h0000_0010;
   localparam logic [31:0] OFF_MASK_CLR   = 32'h0000_0014;

   // bit positions shared by flags and mask
   localparam int BIT_GATE  = 31;
   localparam int BIT_OWNER = 30;
   localparam int BIT_HUB   = 6;
   localparam int BIT_WRAP  = 5;
   localparam int BIT_FATAL = 4;
   localparam int BIT_WAKE  = 3;
   localparam int BIT_SOF   = 2;
   localparam int BIT_FLUSH = 1;
   localparam int BIT_OVR   = 0;

   // writable positions; bit 4 and 29..7 stay zero
   localparam logic [31:0] MASK_IMPL   = 32'hC000_006F;
   localparam logic [31:0] STAT_IMPL   = 32'h4000_006F;

   // values after reset
   localparam logic [31:0] MASK_RESET  = 32'h8000_0000;
   localparam logic [31:0] STAT_RESET  = 32'h0000_0000;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
   localparam logic [31:0] ADDR_RESET  = 32'h0000_0000;

   // bus encodings
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0]  HSIZE_WORD    = 3'h2;

   // one-cycle event pulses from the list engine
   typedef struct packed {
      logic owner_handoff_event;
      logic port_hub_change_event;
      logic frame_count_wrap_event;
      logic wakeup_signal_event;
      logic frame_begin_event;
      logic completion_list_flush_event;
      logic schedule_overrun_event;
   } uhim_events_t;

   // register write from the bus slave, valid for one cycle
   typedef struct packed {
      logic        strobe;
      logic [31:0] addr;
      logic [31:0] data;
   } uhim_wr_t;

endpackage
`default_nettype wire

/* verilog/uhim_top.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - mask bit 3 gates wakeup events, bit 2 frame begin events.
// - mask bit 1 gates list flush events, bit 0 schedule overrun.
// - bit 4 exists in neither view; writes to it are ignored.
// - each clear-view bit acts on the same mask and flag position.
// - writing one to a clear-view bit clears that mask bit.
// - writing zero to a clear-view bit leaves the mask bit alone.
// - reading the clear view returns the live mask.
// - one at clear-view bit 31 drops the global gate; zero does nothing.
// - hardware or software reset sets the global gate bit.
// - one at clear-view bit 30 disables owner handoff interrupts.
// - clear-view bits 6, 5, 3 disable hub, wrap, wakeup interrupts.
// - clear-view bits 2, 1, 0 disable frame, flush, overrun interrupts.
// - all bits other than the gate reset to zero.
// - interrupt when flag, its mask bit and the gate are all set.
// - set view: one sets, zero keeps, read returns the live mask.
module uhim_top
   import uhim_pkg::*;
(
   input  wire logic         clk_in,        // 10 MHz controller clock
   input  wire logic         rst_n_in,      // async reset, low
   input  wire logic         soft_reset_in, // software reset pulse
   input  wire logic         hsel_in,       // ahb slave select
   input  wire logic  [31:0] haddr_in,      // ahb byte address
   input  wire logic  [1:0]  htrans_in,     // ahb transfer type
   input  wire logic         hwrite_in,     // ahb write
   input  wire logic  [2:0]  hsize_in,      // ahb size
   input  wire logic  [31:0] hwdata_in,     // ahb write data
   input  wire logic         hready_in,     // ahb bus ready
   input  wire uhim_events_t events_in,     // event pulses
   output logic       [31:0] hrdata_out,    // ahb read data
   output logic              hreadyout_out, // ahb slave ready
   output logic              hresp_out,     // ahb response
   output logic              irq_out        // level interrupt
);

   // ============================================================
   // bus slave
   // ============================================================

   uhim_wr_t    wr;
   logic [31:0] rd_addr;
   logic [31:0] rd_data;

   uhim_ahb_slave u_slave (
      .clk_in        (clk_in),
      .rst_n_in      (rst_n_in),
      .hsel_in       (hsel_in),
      .haddr_in      (haddr_in),
      .htrans_in     (htrans_in),
      .hwrite_in     (hwrite_in),
      .hsize_in      (hsize_in),
      .hwdata_in     (hwdata_in),
      .hready_in     (hready_in),
      .rd_data_in    (rd_data),
      .hrdata_out    (hrdata_out),
      .hreadyout_out (hreadyout_out),
      .hresp_out     (hresp_out),
      .wr_out        (wr),
      .rd_addr_out   (rd_addr)
   );

   // ============================================================
   // write decode
   // ============================================================

   logic        set_hit;
   logic        clr_hit;
   logic        flag_hit;
   logic [31:0] wdata_impl;
   logic [31:0] ev_vec;

   // unmapped writes fall through all three hits and are lost
   assign set_hit  = wr.strobe && (wr.addr == OFF_MASK_SET);
   assign clr_hit  = wr.strobe && (wr.addr == OFF_MASK_CLR);
   assign flag_hit = wr.strobe && (wr.addr == OFF_EVENT_FLAG);

   // reserved bits dropped
   // reserved and unimplemented positions never reach state
   assign wdata_impl = wr.data & MASK_IMPL;

   // events laid out at their flag positions
   assign ev_vec = {1'b0,
                    events_in.owner_handoff_event,
                    23'h000000,
                    events_in.port_hub_change_event,
                    events_in.frame_count_wrap_event,
                    1'b0,
                    events_in.wakeup_signal_event,
                    events_in.frame_begin_event,
                    events_in.completion_list_flush_event,
                    events_in.schedule_overrun_event};

   // ============================================================
   // shared mask, seen through the set and clear views
   // ============================================================

   logic [31:0] mask_reg;
   logic [31:0] mask_next;

   // next mask; one write can only hit one view, so no priority
   // between set and clear is needed
   always_comb begin
      mask_next = mask_reg;
      if (soft_reset_in) begin
         mask_next = MASK_RESET;
      end else if (set_hit) begin
         mask_next = mask_reg | wdata_impl;
      end else if (clr_hit) begin
         mask_next = mask_reg & ~wdata_impl;
      end
   end

   // mask register
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mask_reg <= MASK_RESET;
      end else begin
         mask_reg <= mask_next;
      end
   end

   // ============================================================
   // sticky event flags, write one to clear
   // ============================================================

   logic [31:0] status_reg;
   logic [31:0] status_next;
   logic [31:0] flag_clr;

   // an event in the clearing cycle survives: set wins over clear
   always_comb begin
      flag_clr    = flag_hit ? (wr.data & STAT_IMPL) : STAT_RESET;
      status_next = (status_reg & ~flag_clr) | (ev_vec & STAT_IMPL);
   end

   // flag register
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         status_reg <= STAT_RESET;
      end else begin
         status_reg <= status_next;
      end
   end

   // ============================================================
   // interrupt request
   // ============================================================

   assign irq_out = mask_reg[BIT_GATE]
                    && (|(status_reg & mask_reg & STAT_IMPL));

   // ============================================================
   // read decode
   // ============================================================

   // both views return the one mask; no shadow copy exists
   always_comb begin
      if (rd_addr == OFF_MASK_CLR) begin
         rd_data = mask_reg;
      end else if (rd_addr == OFF_MASK_SET) begin
         rd_data = mask_reg;
      end else if (rd_addr == OFF_EVENT_FLAG) begin
         rd_data = status_reg;
      end else begin
         // unmapped reads answer zero
         rd_data = RDATA_RESET;
      end
   end

   // ============================================================
   // checks
   // ============================================================

   // write phases as seen at the register port
   sequence s_clr_write;
      clr_hit && !soft_reset_in;
   endsequence

   sequence s_set_write;
      set_hit && !soft_reset_in;
   endsequence

   // a word read of the clear view taken on the bus
   sequence s_clr_read;
      hsel_in && (htrans_in == HTRANS_NONSEQ) && !hwrite_in
      && hready_in && (haddr_in == OFF_MASK_CLR);
   endsequence

   // a word read of the set view taken on the bus
   sequence s_set_read;
      hsel_in && (htrans_in == HTRANS_NONSEQ) && !hwrite_in
      && hready_in && (haddr_in == OFF_MASK_SET);
   endsequence

   // an enabled event arriving with the gate open
   sequence s_armed_event;
      mask_reg[BIT_GATE] && !soft_reset_in && !clr_hit
      && (|(ev_vec & mask_reg & STAT_IMPL));
   endsequence

   a_clr_ones_clear: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      s_clr_write |=> ((mask_reg & $past(wdata_impl)) == 32'h0000_0000))
      else $error("clear view write left a mask bit set");

   a_clr_zeros_keep: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      s_clr_write |=> ((mask_reg & ~$past(wdata_impl))
                       == ($past(mask_reg) & ~$past(wdata_impl))))
      else $error("clear view zero changed a mask bit");

   a_set_ones_set: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      s_set_write |=> ((mask_reg & $past(wdata_impl))
                       == $past(wdata_impl))
                      && ((mask_reg & ~$past(wdata_impl))
                          == ($past(mask_reg) & ~$past(wdata_impl))))
      else $error("set view write did not set exactly its ones");

   a_clr_read_mirror: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      s_clr_read |-> ##2 (hreadyout_out
                          && (hrdata_out == $past(mask_reg))))
      else $error("clear view read did not return the mask");

   a_set_read_mirror: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      s_set_read |-> ##2 (hreadyout_out
                          && (hrdata_out == $past(mask_reg))))
      else $error("set view read did not return the mask");

   a_soft_reset_gate: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      soft_reset_in |=> (mask_reg == MASK_RESET))
      else $error("software reset did not restore the mask");

   a_fatal_bit_zero: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      $changed(mask_reg) |-> !mask_reg[BIT_FATAL] && !status_reg[BIT_FATAL])
      else $error("unimplemented bit 4 became set");

   a_reserved_zero: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (set_hit || clr_hit) |-> ##1 ((rd_data & ~MASK_IMPL) == 32'h0000_0000))
      else $error("reserved mask bits became visible");

   a_irq_follows_event: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      s_armed_event |=> irq_out)
      else $error("enabled event did not raise the interrupt");

   a_gate_blocks_irq: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (clr_hit && wr.data[BIT_GATE] && !soft_reset_in) |=> !irq_out [*2])
      else $error("interrupt seen after the gate was cleared");

   a_owner_disable: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (clr_hit && wr.data[BIT_OWNER] && !soft_reset_in)
      |=> !mask_reg[BIT_OWNER])
      else $error("owner handoff mask bit not cleared");

   a_low_disable: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (clr_hit && !soft_reset_in && wr.data[BIT_HUB] && wr.data[BIT_WRAP]
       && wr.data[BIT_WAKE] && wr.data[BIT_SOF] && wr.data[BIT_FLUSH]
       && wr.data[BIT_OVR]) |=> (mask_reg[6:0] == 7'h00))
      else $error("low mask bits not cleared");

   // unmapped writes leave the mask alone
   a_unmapped_ignored: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (wr.strobe && !set_hit && !clr_hit && !soft_reset_in)
      |=> $stable(mask_reg))
      else $error("unmapped write changed the mask");

   // flags are sticky: set wins over a same-cycle clear
   a_flag_set_wins: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (flag_hit && events_in.frame_begin_event) |=> status_reg[BIT_SOF])
      else $error("event lost to a same-cycle flag clear");

endmodule
`default_nettype wire
